// >>> serial_port_pkg.sv
package serial_port_pkg;
  // How it works
  // - every link line is asserted at low level
  // - module is DCE, host drives data, rts, dtr
  // - frames are 8 data bits, no parity, 1 stop
  // - divisor held between 300 and 115200 bps
  // - autobaud locks only to eight listed rates
  // - rts and cts gate the partner's transmitter
  // - received xoff pauses, xon resumes transmitter
  // - ring output, level or pulse mode selectable
  // - terminal ready sampled once per second

  // ************************************
  // timing
  // ************************************
  localparam int CLK_HZ       = 25_000_000;
  localparam int SEC_TIME_S   = 1;
  localparam int SEC_CYC_DEF  = CLK_HZ * SEC_TIME_S;
  localparam int RING_TIME_MS = 100;
  localparam int RING_CYC_DEF = CLK_HZ / 1000 * RING_TIME_MS;
  localparam int MIN_RATE     = 300;
  localparam int MAX_RATE     = 115_200;
  localparam int RESET_RATE   = 9600;
  localparam logic [16:0] DIV_MIN   = 17'(CLK_HZ / MAX_RATE);
  localparam logic [16:0] DIV_MAX   = 17'(CLK_HZ / MIN_RATE);
  localparam logic [16:0] DIV_RESET = 17'(CLK_HZ / RESET_RATE);
  localparam logic [3:0]  STOP_BIT  = 4'h9;
  localparam logic [7:0]  XOFF_CODE = 8'h13;
  localparam logic [7:0]  XON_CODE  = 8'h11;

  // ************************************
  // register map
  // ************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIV  = 8'h04;
  localparam logic [7:0] OFF_TX   = 8'h08;
  localparam logic [7:0] OFF_RX   = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_RING = 8'h14;
  localparam int CTRL_HW    = 0;
  localparam int CTRL_SW    = 1;
  localparam int CTRL_AB    = 2;
  localparam int CTRL_DSR   = 3;
  localparam int CTRL_DTR   = 3;
  localparam int CTRL_DCD   = 4;
  localparam int CTRL_RMODE = 5;
  localparam int CTRL_RLVL  = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam int ST_BUSY  = 0;
  localparam int ST_FULL  = 1;
  localparam int ST_OVR   = 2;
  localparam int ST_FERR  = 3;
  localparam int ST_PAUSE = 4;
  localparam int ST_DTR   = 5;
  localparam int ST_DSR   = 5;
  localparam int ST_RTS   = 6;
  localparam int ST_CTS   = 6;
  localparam int ST_LOCK  = 7;
  localparam int ST_DCD   = 7;
  localparam int ST_RING  = 8;

  // ************************************
  // serial engines
  // ************************************
  typedef struct packed {
    logic        busy;
    logic        line;
    logic [3:0]  bitn;
    logic [16:0] cnt;
    logic [9:0]  sh;
  } tx_t;
  typedef struct packed {
    logic        busy;
    logic        done;
    logic        ferr;
    logic [3:0]  bitn;
    logic [16:0] cnt;
    logic [7:0]  sh;
  } rx_t;
  typedef enum logic [2:0] {
    AB_IDLE = 3'b001,
    AB_MEAS = 3'b010,
    AB_WAIT = 3'b100
  } ab_state_t;
  localparam tx_t TX_IDLE = '{1'b0, 1'b1, 4'h0, 17'h0, 10'h3ff};
  localparam rx_t RX_IDLE = '{1'b0, 1'b0, 1'b0, 4'h0, 17'h0, 8'h00};

  function automatic logic [16:0] clamp_div(input logic [31:0] v);
    if (v < 32'(DIV_MIN))
      return DIV_MIN;
    if (v > 32'(DIV_MAX))
      return DIV_MAX;
    return v[16:0];
  endfunction : clamp_div

  function automatic logic [16:0] rate_div(input logic [2:0] i);
    case (i)
      3'h0:    return 17'(CLK_HZ / 1200);
      3'h1:    return 17'(CLK_HZ / 2400);
      3'h2:    return 17'(CLK_HZ / 4800);
      3'h3:    return 17'(CLK_HZ / 9600);
      3'h4:    return 17'(CLK_HZ / 19200);
      3'h5:    return 17'(CLK_HZ / 38400);
      3'h6:    return 17'(CLK_HZ / 57600);
      default: return DIV_MIN;
    endcase
  endfunction : rate_div

  // within one eighth of a listed bit time; quarter bands would overlap
  function automatic logic [17:0] ab_match(input logic [20:0] c);
    logic [17:0] res;
    logic [16:0] d;
    res = 18'h0;
    for (int i = 0; i < 8; i++)
    begin
      d = rate_div(3'(i));
      if (c > 21'(d - (d >> 3)) && c < 21'(d + (d >> 3)))
        res = {1'b1, d};
    end
    return res;
  endfunction : ab_match

  function automatic tx_t tx_step(input tx_t s, input logic [16:0] div,
                                  input logic go, input logic [7:0] d);
    tx_t n;
    n = s;
    if (!s.busy)
    begin
      n.line = 1'b1;
      if (go)
      begin
        n.sh   = {1'b1, d, 1'b0};
        n.line = 1'b0;
        n.busy = 1'b1;
        n.bitn = 4'h0;
        n.cnt  = div - 17'h1;
      end
    end
    else if (s.cnt != 17'h0)
      n.cnt = s.cnt - 17'h1;
    else if (s.bitn == STOP_BIT)
      n.busy = 1'b0;
    else
    begin
      n.sh   = {1'b1, s.sh[9:1]};
      n.line = s.sh[1];
      n.bitn = s.bitn + 4'h1;
      n.cnt  = div - 17'h1;
    end
    return n;
  endfunction : tx_step

  function automatic rx_t rx_step(input rx_t s, input logic [16:0] div,
                                  input logic line);
    rx_t n;
    n = s;
    n.done = 1'b0;
    n.ferr = 1'b0;
    if (!s.busy)
    begin
      if (!line)
      begin
        n.busy = 1'b1;
        n.bitn = 4'h0;
        n.cnt  = div >> 1;
      end
    end
    else if (s.cnt != 17'h0)
      n.cnt = s.cnt - 17'h1;
    else
    begin
      n.cnt  = div - 17'h1;
      n.bitn = s.bitn + 4'h1;
      if (s.bitn == 4'h0 && line)
        n.busy = 1'b0;
      else if (s.bitn == STOP_BIT)
      begin
        n.busy = 1'b0;
        n.done = line;
        n.ferr = ~line;
      end
      else if (s.bitn != 4'h0)
        n.sh = {line, s.sh[7:1]};
    end
    return n;
  endfunction : rx_step
endpackage : serial_port_pkg

// >>> serial_link_if.sv
`timescale 1ns/1ps
// pin levels; all low active at the connector
interface serial_link_if;
  logic host_to_module_serial_in_n;
  logic module_to_host_serial_out_n;
  logic request_to_send_in_n;
  logic clear_to_send_out_n;
  logic terminal_ready_in_n;
  logic set_ready_out_n;
  logic carrier_detect_out_n;
  logic ring_indicate_out_n;
  modport dce (
    input  host_to_module_serial_in_n,
    input  request_to_send_in_n,
    input  terminal_ready_in_n,
    output module_to_host_serial_out_n,
    output clear_to_send_out_n,
    output set_ready_out_n,
    output carrier_detect_out_n,
    output ring_indicate_out_n
  );
  modport dte (
    output host_to_module_serial_in_n,
    output request_to_send_in_n,
    output terminal_ready_in_n,
    input  module_to_host_serial_out_n,
    input  clear_to_send_out_n,
    input  set_ready_out_n,
    input  carrier_detect_out_n,
    input  ring_indicate_out_n
  );
endinterface : serial_link_if

// >>> dce_async_serial_port.sv
`timescale 1ns/1ps
module dce_async_serial_port #(
  parameter logic [24:0] SEC_CYC  = 25'(serial_port_pkg::SEC_CYC_DEF),
  parameter logic [24:0] RING_CYC = 25'(serial_port_pkg::RING_CYC_DEF)
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link toward the host
  serial_link_if.dce       link
);
  import serial_port_pkg::*;

  // ************************************
  // state
  // ************************************
  typedef struct packed {
    logic [6:0]  ctrl;
    logic [16:0] div;
    tx_t         tx;
    rx_t         rx;
    logic [7:0]  txbuf;
    logic        tx_pend;
    logic [7:0]  rxbuf;
    logic        rx_full;
    logic        fresh;
    logic        ovr;
    logic        ferr;
    logic        paused;
    ab_state_t   ab;
    logic [20:0] ab_cnt;
    logic        locked;
    logic [24:0] sec_cnt;
    logic        dtr_seen;
    logic [24:0] ring_cnt;
    logic        cts_n;
    logic        dsr_n;
    logic        dcd_n;
    logic        ring_n;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dev_t;

  localparam dev_t DEV_RESET = '{
    ctrl: CTRL_RESET, div: DIV_RESET, tx: TX_IDLE, rx: RX_IDLE,
    ab: AB_IDLE, dsr_n: 1'b1, dcd_n: 1'b1, ring_n: 1'b1,
    txbuf: 8'h00, tx_pend: 1'b0, rxbuf: 8'h00, rx_full: 1'b0,
    fresh: 1'b0, ovr: 1'b0, ferr: 1'b0, paused: 1'b0,
    ab_cnt: 21'h0, locked: 1'b0, sec_cnt: 25'h0, dtr_seen: 1'b0,
    ring_cnt: 25'h0, cts_n: 1'b0, prdata: 32'h0, pready: 1'b0,
    pslverr: 1'b0};

  dev_t        state;
  dev_t        next_state;
  logic        setup;
  logic        wr;
  logic        rd;
  logic        rxl;
  logic        hw;
  logic        sw;
  logic        ab_on;
  logic        tx_go;
  logic        rx_en;
  logic        ab_hit;
  logic [16:0] ab_div;
  logic [8:0]  stat;

  assign setup = psel & ~penable;
  assign wr    = psel & penable & state.pready & pwrite;
  assign rd    = psel & penable & state.pready & ~pwrite;
  assign rxl   = link.host_to_module_serial_in_n;
  assign hw    = state.ctrl[CTRL_HW];
  assign sw    = state.ctrl[CTRL_SW];
  assign ab_on = state.ctrl[CTRL_AB];
  assign {ab_hit, ab_div} = ab_match(state.ab_cnt);

  // host rts high: hold our transmitter
  assign tx_go = state.tx_pend & ~state.tx.busy
               & ~(hw & link.request_to_send_in_n)
               & ~(sw & state.paused)
               & (~ab_on | state.locked);
  // receiver ignores the line while the rate is being measured
  assign rx_en = ~ab_on | (state.locked & state.ab == AB_IDLE);

  assign stat[ST_BUSY]  = state.tx_pend | state.tx.busy;
  assign stat[ST_FULL]  = state.rx_full;
  assign stat[ST_OVR]   = state.ovr;
  assign stat[ST_FERR]  = state.ferr;
  assign stat[ST_PAUSE] = state.paused;
  assign stat[ST_DTR]   = state.dtr_seen;
  assign stat[ST_RTS]   = ~link.request_to_send_in_n;
  assign stat[ST_LOCK]  = state.locked;
  assign stat[ST_RING]  = ~state.ring_n;

  // ************************************
  // next state
  // ************************************
  always_comb
  begin
    next_state = state;
    next_state.pready = setup;
    if (setup)
    begin
      next_state.prdata  = 32'h0;
      next_state.pslverr = 1'b0;
      case (paddr)
        OFF_CTRL: next_state.prdata = 32'(state.ctrl);
        OFF_DIV:  next_state.prdata = 32'(state.div);
        OFF_TX:   next_state.prdata = 32'h0;
        OFF_RX:
        begin
          next_state.prdata = 32'(state.rxbuf);
          next_state.fresh  = 1'b0;
        end
        OFF_STAT: next_state.prdata = 32'(stat);
        OFF_RING: next_state.prdata = 32'h0;
        default:  next_state.pslverr = 1'b1;
      endcase
    end
    if (state.ring_cnt != 25'h0)
      next_state.ring_cnt = state.ring_cnt - 25'h1;
    if (wr)
    begin
      case (paddr)
        OFF_CTRL:
        begin
          next_state.ctrl = pwdata[6:0];
          if (pwdata[CTRL_AB])
          begin
            next_state.locked = 1'b0;
            next_state.ab     = AB_IDLE;
          end
        end
        OFF_DIV: next_state.div = clamp_div(pwdata);
        OFF_TX:
        begin
          if (!state.tx_pend)
          begin
            next_state.txbuf   = pwdata[7:0];
            next_state.tx_pend = 1'b1;
          end
        end
        OFF_STAT:
        begin
          if (pwdata[ST_OVR])
            next_state.ovr = 1'b0;
          if (pwdata[ST_FERR])
            next_state.ferr = 1'b0;
        end
        OFF_RING:
        begin
          if (state.ctrl[CTRL_RMODE])
            next_state.ring_cnt = RING_CYC;
        end
        default: ;
      endcase
    end
    // data loaded after the snapshot must survive the pop
    if (rd && paddr == OFF_RX && !state.fresh)
      next_state.rx_full = 1'b0;

    // transmitter
    if (tx_go)
      next_state.tx_pend = 1'b0;
    next_state.tx = tx_step(state.tx, state.div, tx_go, state.txbuf);

    // receiver; event sets come after software clears
    next_state.rx = rx_en ? rx_step(state.rx, state.div, rxl) : RX_IDLE;
    if (!sw)
      next_state.paused = 1'b0;
    if (state.rx.done)
    begin
      if (sw && state.rx.sh == XOFF_CODE)
        next_state.paused = 1'b1;
      else if (sw && state.rx.sh == XON_CODE)
        next_state.paused = 1'b0;
      else if (next_state.rx_full)
        next_state.ovr = 1'b1;
      else
      begin
        next_state.rxbuf   = state.rx.sh;
        next_state.rx_full = 1'b1;
        next_state.fresh   = 1'b1;
      end
    end
    if (state.rx.ferr)
      next_state.ferr = 1'b1;

    // autobaud: width of the start bit of the first character
    case (state.ab)
      AB_IDLE:
      begin
        if (ab_on && !state.locked && !rxl)
        begin
          next_state.ab     = AB_MEAS;
          next_state.ab_cnt = 21'h1;
        end
      end
      AB_MEAS:
      begin
        if (!rxl)
        begin
          if (state.ab_cnt != 21'h1fffff)
            next_state.ab_cnt = state.ab_cnt + 21'h1;
        end
        else if (ab_hit)
        begin
          next_state.div    = ab_div;
          next_state.locked = 1'b1;
          next_state.ab     = AB_WAIT;
          next_state.ab_cnt = 21'h0;
        end
        else
          next_state.ab = AB_IDLE;
      end
      AB_WAIT:
      begin
        // sixteen idle bit times end the measured character
        if (!rxl)
          next_state.ab_cnt = 21'h0;
        else if (state.ab_cnt >= {state.div, 4'h0})
          next_state.ab = AB_IDLE;
        else
          next_state.ab_cnt = state.ab_cnt + 21'h1;
      end
      default: next_state.ab = AB_IDLE;
    endcase

    // terminal ready polled once a second, so short pulses are missed
    if (state.sec_cnt >= SEC_CYC - 25'h1)
    begin
      next_state.sec_cnt  = 25'h0;
      next_state.dtr_seen = ~link.terminal_ready_in_n;
    end
    else
      next_state.sec_cnt = state.sec_cnt + 25'h1;

    // pins, asserted low
    next_state.cts_n = next_state.ctrl[CTRL_HW]
                     & next_state.rx_full;
    next_state.dsr_n = ~next_state.ctrl[CTRL_DSR];
    next_state.dcd_n = ~next_state.ctrl[CTRL_DCD];
    next_state.ring_n = next_state.ctrl[CTRL_RMODE]
                      ? (next_state.ring_cnt == 25'h0)
                      : ~next_state.ctrl[CTRL_RLVL];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= DEV_RESET;
    else
      state <= next_state;
  end

  // ************************************
  // outputs
  // ************************************
  assign prdata  = state.prdata;
  assign pready  = state.pready;
  assign pslverr = state.pslverr;
  assign link.module_to_host_serial_out_n = state.tx.line;
  assign link.clear_to_send_out_n  = state.cts_n;
  assign link.set_ready_out_n      = state.dsr_n;
  assign link.carrier_detect_out_n = state.dcd_n;
  assign link.ring_indicate_out_n  = state.ring_n;
endmodule : dce_async_serial_port

// >>> dte_serial_host.sv
`timescale 1ns/1ps
module dte_serial_host #(
  parameter logic [24:0] HOLD_CYC = 25'(serial_port_pkg::SEC_CYC_DEF)
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link toward the module
  serial_link_if.dte       link
);
  import serial_port_pkg::*;

  typedef struct packed {
    logic [3:0]  ctrl;
    logic [16:0] div;
    tx_t         tx;
    rx_t         rx;
    logic [7:0]  txbuf;
    logic        tx_pend;
    logic [7:0]  rxbuf;
    logic        rx_full;
    logic        fresh;
    logic        ovr;
    logic        ferr;
    logic        paused;
    logic        rts_n;
    logic        dtr_n;
    logic [24:0] hold;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } host_t;

  localparam host_t HOST_RESET = '{
    ctrl: 4'h0, div: DIV_RESET, tx: TX_IDLE, rx: RX_IDLE,
    txbuf: 8'h00, tx_pend: 1'b0, rxbuf: 8'h00, rx_full: 1'b0,
    fresh: 1'b0, ovr: 1'b0, ferr: 1'b0, paused: 1'b0, rts_n: 1'b0,
    dtr_n: 1'b1, hold: 25'h0, prdata: 32'h0, pready: 1'b0,
    pslverr: 1'b0};

  host_t      state;
  host_t      next_state;
  logic       setup;
  logic       wr;
  logic       rd;
  logic       tx_go;
  logic [8:0] stat;

  assign setup = psel & ~penable;
  assign wr    = psel & penable & state.pready & pwrite;
  assign rd    = psel & penable & state.pready & ~pwrite;
  assign tx_go = state.tx_pend & ~state.tx.busy
               & ~(state.ctrl[CTRL_HW] & link.clear_to_send_out_n)
               & ~(state.ctrl[CTRL_SW] & state.paused);

  assign stat[ST_BUSY]  = state.tx_pend | state.tx.busy;
  assign stat[ST_FULL]  = state.rx_full;
  assign stat[ST_OVR]   = state.ovr;
  assign stat[ST_FERR]  = state.ferr;
  assign stat[ST_PAUSE] = state.paused;
  assign stat[ST_DSR]   = ~link.set_ready_out_n;
  assign stat[ST_CTS]   = ~link.clear_to_send_out_n;
  assign stat[ST_DCD]   = ~link.carrier_detect_out_n;
  assign stat[ST_RING]  = ~link.ring_indicate_out_n;

  always_comb
  begin
    next_state = state;
    next_state.pready = setup;
    if (setup)
    begin
      next_state.prdata  = 32'h0;
      next_state.pslverr = 1'b0;
      case (paddr)
        OFF_CTRL: next_state.prdata = 32'(state.ctrl);
        OFF_DIV:  next_state.prdata = 32'(state.div);
        OFF_TX:   next_state.prdata = 32'h0;
        OFF_RX:
        begin
          next_state.prdata = 32'(state.rxbuf);
          next_state.fresh  = 1'b0;
        end
        OFF_STAT: next_state.prdata = 32'(stat);
        default:  next_state.pslverr = 1'b1;
      endcase
    end
    if (wr)
    begin
      case (paddr)
        OFF_CTRL: next_state.ctrl = pwdata[3:0];
        OFF_DIV:  next_state.div  = clamp_div(pwdata);
        OFF_TX:
        begin
          if (!state.tx_pend)
          begin
            next_state.txbuf   = pwdata[7:0];
            next_state.tx_pend = 1'b1;
          end
        end
        OFF_STAT:
        begin
          if (pwdata[ST_OVR])
            next_state.ovr = 1'b0;
          if (pwdata[ST_FERR])
            next_state.ferr = 1'b0;
        end
        default: ;
      endcase
    end
    if (rd && paddr == OFF_RX && !state.fresh)
      next_state.rx_full = 1'b0;

    if (tx_go)
      next_state.tx_pend = 1'b0;
    next_state.tx = tx_step(state.tx, state.div, tx_go, state.txbuf);
    next_state.rx = rx_step(state.rx, state.div,
                            link.module_to_host_serial_out_n);
    if (!state.ctrl[CTRL_SW])
      next_state.paused = 1'b0;
    if (state.rx.done)
    begin
      if (state.ctrl[CTRL_SW] && state.rx.sh == XOFF_CODE)
        next_state.paused = 1'b1;
      else if (state.ctrl[CTRL_SW] && state.rx.sh == XON_CODE)
        next_state.paused = 1'b0;
      else if (next_state.rx_full)
        next_state.ovr = 1'b1;
      else
      begin
        next_state.rxbuf   = state.rx.sh;
        next_state.rx_full = 1'b1;
        next_state.fresh   = 1'b1;
      end
    end
    if (state.rx.ferr)
      next_state.ferr = 1'b1;

    // a slow poller at the far end: hold every dtr level long enough
    if (state.hold != 25'h0)
      next_state.hold = state.hold - 25'h1;
    else if (state.dtr_n == state.ctrl[CTRL_DTR])
    begin
      next_state.dtr_n = ~state.ctrl[CTRL_DTR];
      next_state.hold  = HOLD_CYC - 25'h1;
    end
    next_state.rts_n = next_state.ctrl[CTRL_HW]
                     & next_state.rx_full;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= HOST_RESET;
    else
      state <= next_state;
  end

  assign prdata  = state.prdata;
  assign pready  = state.pready;
  assign pslverr = state.pslverr;
  assign link.host_to_module_serial_in_n = state.tx.line;
  assign link.request_to_send_in_n = state.rts_n;
  assign link.terminal_ready_in_n  = state.dtr_n;
endmodule : dte_serial_host

// >>> serial_link_props.sv
`timescale 1ns/1ps
module serial_link_props #(
  parameter int HOLD = 200,
  parameter int BIT  = 217
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link pins, low active
  input wire logic host_to_module_serial_in_n,
  input wire logic module_to_host_serial_out_n,
  input wire logic request_to_send_in_n,
  input wire logic clear_to_send_out_n,
  input wire logic terminal_ready_in_n,
  input wire logic set_ready_out_n,
  input wire logic carrier_detect_out_n,
  input wire logic ring_indicate_out_n
);
  // ************************************
  // run counters
  // ************************************
  logic [1:0]  ln;
  logic [1:0]  lp;
  logic [16:0] lo [2];
  logic [16:0] hi [2];
  logic [11:0] fc;
  logic [7:0]  dc;
  logic        dp;
  assign ln = {host_to_module_serial_in_n, module_to_host_serial_out_n};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lp <= 2'b11;
      lo <= '{default: '0};
      hi <= '{default: '0};
      fc <= '0;
      dc <= 8'hff;
      dp <= 1'b1;
    end
    else
    begin
      lp <= ln;
      dp <= terminal_ready_in_n;
      dc <= (dp != terminal_ready_in_n) ? 8'h1 : dc + 8'(dc != 8'hff);
      for (int i = 0; i < 2; i++)
      begin
        lo[i] <= ln[i] ? '0 : lo[i] + 17'h1;
        hi[i] <= !ln[i] ? '0 : hi[i] + 17'(hi[i] != '1);
      end
      // frame timer, module output only, at BIT
      if (fc != '0)
        fc <= fc - 12'h1;
      else if (lp[0] && !ln[0])
        fc <= 12'(10 * BIT - 1);
    end
  // ************************************
  // properties
  // ************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_idle: assert property ($rose(presetn) |-> ln == 2'b11
    && !clear_to_send_out_n && set_ready_out_n && carrier_detect_out_n
    && ring_indicate_out_n) else $error("link not idle after reset");
  a_low_run_in: assert property (!lp[1] && ln[1] |->
    lo[1] % BIT == 0 && lo[1] >= BIT) else $error("bad low run in");
  a_low_run_out: assert property (!lp[0] && ln[0] |->
    lo[0] % BIT == 0 && lo[0] >= BIT) else $error("bad low run out");
  a_high_run_in: assert property (lp[1] && !ln[1] |->
    hi[1] >= BIT) else $error("short high run in");
  a_stop_bit: assert property (fc != '0 && fc <= BIT |->
    ln[0]) else $error("stop bit not high");
  a_start_bit: assert property (fc > 9 * BIT |-> !ln[0])
    else $error("start bit not low");
  a_rts_gate: assert property (lp[0] && !ln[0] && fc == '0 |->
    !($past(request_to_send_in_n) && $past(request_to_send_in_n, 2)))
    else $error("start while rts high");
  a_dtr_hold: assert property (dp != terminal_ready_in_n |->
    dc >= HOLD) else $error("dtr held too short");
endmodule : serial_link_props

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  import serial_port_pkg::*;
  logic             pclk      = 1'b0;
  logic             presetn   = 1'b0;
  logic [1:0]       psel      = '0;
  logic [1:0]       penable   = '0;
  logic [1:0]       pwrite    = '0;
  logic [1:0][7:0]  paddr     = '0;
  logic [1:0][31:0] pwdata    = '0;
  logic [1:0][31:0] prdata;
  logic [1:0]       pready;
  logic [1:0]       pslverr;
  logic [31:0]      q;
  logic             er;
  int               n_fail    = 0;
  int               tests_run = 0;
  logic [7:0]       pat [3]   = '{8'h00, 8'hff, 8'ha5};
  // ************************************
  // ends under test, index 0 module, 1 host
  // ************************************
  always #20 pclk = ~pclk;
  serial_link_if link ();
  dce_async_serial_port #(.SEC_CYC(25'd200), .RING_CYC(25'd50))
  u_dce_async_serial_port (.pclk(pclk), .presetn(presetn), .psel(psel[0]),
    .penable(penable[0]), .pwrite(pwrite[0]), .paddr(paddr[0]),
    .pwdata(pwdata[0]), .prdata(prdata[0]), .pready(pready[0]),
    .pslverr(pslverr[0]), .link(link));
  dte_serial_host #(.HOLD_CYC(25'd200))
  u_dte_serial_host (.pclk(pclk), .presetn(presetn), .psel(psel[1]),
    .penable(penable[1]), .pwrite(pwrite[1]), .paddr(paddr[1]),
    .pwdata(pwdata[1]), .prdata(prdata[1]), .pready(pready[1]),
    .pslverr(pslverr[1]), .link(link));
  serial_link_props #(.HOLD(200), .BIT(217))
  u_serial_link_props (.pclk(pclk), .presetn(presetn),
    .host_to_module_serial_in_n(link.host_to_module_serial_in_n),
    .module_to_host_serial_out_n(link.module_to_host_serial_out_n),
    .request_to_send_in_n(link.request_to_send_in_n),
    .clear_to_send_out_n(link.clear_to_send_out_n),
    .terminal_ready_in_n(link.terminal_ready_in_n),
    .set_ready_out_n(link.set_ready_out_n),
    .carrier_detect_out_n(link.carrier_detect_out_n),
    .ring_indicate_out_n(link.ring_indicate_out_n));
  // ************************************
  // bus tasks
  // ************************************
  task stop_test();
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask : chk
  task xfer(input int w, input logic wr, input logic [7:0] a,
            input logic [31:0] d = '0);
    int n;
    @(posedge pclk);
    psel[w]   <= 1'b1;
    pwrite[w] <= wr;
    paddr[w]  <= a;
    pwdata[w] <= d;
    @(posedge pclk);
    penable[w] <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready[w] !== 1'b1 && n < 8);
    if (pready[w] !== 1'b1)
    begin
      n_fail++;
      stop_test();
    end
    q  = prdata[w];
    er = pslverr[w];
    psel[w]    <= 1'b0;
    penable[w] <= 1'b0;
  endtask : xfer
  task wait_st(input int w, input int b, input logic v);
    int k;
    for (k = 0; k < 5000; k++)
    begin
      xfer(w, 1'b0, OFF_STAT);
      if (q[b] === v)
        break;
    end
    if (k == 5000)
    begin
      n_fail++;
      stop_test();
    end
  endtask : wait_st
  task rx(input int w, input logic [7:0] e);
    wait_st(w, ST_FULL, 1'b1);
    xfer(w, 1'b0, OFF_RX);
    chk("rx byte", q, 32'(e));
  endtask : rx
  // ************************************
  // sequence
  // ************************************
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, 1'b0, OFF_DIV);
    chk("div reset", q, 32'(DIV_RESET));
    xfer(1, 1'b1, OFF_DIV, 32'h5);
    xfer(1, 1'b0, OFF_DIV);
    chk("div clamp", q, 32'(DIV_MIN));
    xfer(0, 1'b0, 8'h40);
    chk("unmapped", 32'(er), 32'h1);
    xfer(1, 1'b0, OFF_RING);
    chk("host unmapped", 32'(er), 32'h1);
    xfer(0, 1'b1, OFF_DIV, 32'd217);
    for (int w = 0; w < 2; w++)
      xfer(w, 1'b1, OFF_CTRL, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      xfer(i % 2, 1'b1, OFF_TX, 32'(pat[i / 2]));
      rx(1 - i % 2, pat[i / 2]);
    end
    // host full: next char waits
    xfer(0, 1'b1, OFF_TX, 32'h81);
    wait_st(1, ST_FULL, 1'b1);
    xfer(0, 1'b1, OFF_TX, 32'h42);
    repeat (2500) @(posedge pclk);
    xfer(0, 1'b0, OFF_STAT);
    chk("held busy", 32'(q[ST_BUSY]), 32'h1);
    chk("rts seen", 32'(q[ST_RTS]), 32'h0);
    rx(1, 8'h81);
    rx(1, 8'h42);
    for (int w = 0; w < 2; w++)
      xfer(w, 1'b1, OFF_CTRL, 32'h3);
    xfer(1, 1'b1, OFF_TX, 32'(XOFF_CODE));
    wait_st(0, ST_PAUSE, 1'b1);
    xfer(0, 1'b1, OFF_TX, 32'h55);
    repeat (2500) @(posedge pclk);
    xfer(0, 1'b0, OFF_STAT);
    chk("xoff kept", 32'(q[ST_FULL:ST_BUSY]), 32'h1);
    xfer(1, 1'b1, OFF_TX, 32'(XON_CODE));
    rx(1, 8'h55);
    xfer(0, 1'b0, OFF_STAT);
    chk("xon kept", 32'(q[ST_PAUSE:ST_FULL]), 32'h0);
    xfer(0, 1'b1, OFF_CTRL, 32'h59);
    xfer(1, 1'b0, OFF_STAT);
    chk("modem on", 32'(q[ST_RING:ST_DSR]), 32'hf);
    xfer(0, 1'b1, OFF_CTRL, 32'h21);
    xfer(0, 1'b1, OFF_RING, 32'h1);
    xfer(1, 1'b0, OFF_STAT);
    chk("ring pulse", 32'(q[ST_RING:ST_DSR]), 32'ha);
    repeat (60) @(posedge pclk);
    xfer(1, 1'b0, OFF_STAT);
    chk("ring off", 32'(q[ST_RING:ST_DSR]), 32'h2);
    // short request, still held
    xfer(1, 1'b1, OFF_CTRL, 32'h9);
    xfer(1, 1'b1, OFF_CTRL, 32'h0);
    wait_st(0, ST_DTR, 1'b1);
    wait_st(0, ST_DTR, 1'b0);
    xfer(1, 1'b1, OFF_DIV, 32'd868);
    xfer(0, 1'b1, OFF_CTRL, 32'h5);
    xfer(1, 1'b1, OFF_TX, 32'h41);
    wait_st(1, ST_BUSY, 1'b0);
    xfer(0, 1'b0, OFF_STAT);
    chk("no lock", 32'(q[ST_LOCK]), 32'h0);
    xfer(1, 1'b1, OFF_DIV, 32'd217);
    xfer(1, 1'b1, OFF_TX, 32'h41);
    wait_st(0, ST_LOCK, 1'b1);
    repeat (6000) @(posedge pclk);
    xfer(1, 1'b1, OFF_TX, 32'h6b);
    rx(0, 8'h6b);
    xfer(0, 1'b1, OFF_TX, 32'h1);
    xfer(0, 1'b1, OFF_TX, 32'h2);
    wait_st(1, ST_OVR, 1'b1);
    xfer(1, 1'b1, OFF_STAT, 32'h4);
    xfer(1, 1'b0, OFF_STAT);
    chk("ovr clear", 32'(q[ST_OVR]), 32'h0);
    stop_test();
  end
endmodule : tb
